// ===== common/smt_cfg.svh
/*
 register offsets, field positions, reset values and timing counts of the
 dual 8-bit timer control block. assumes nothing of its surroundings.
*/
`ifndef SMT_CFG_SVH
`define SMT_CFG_SVH

`define SMT_OFF_CTRL 6'h00
`define SMT_OFF_PINEN 6'h01
`define SMT_OFF_FORCE 6'h02
`define SMT_OFF_SPLIT 6'h03
`define SMT_OFF_CMDCLR 6'h04
`define SMT_OFF_CMDSET 6'h05
`define SMT_OFF_IRQEN 6'h0A
`define SMT_OFF_IRQFL 6'h0B
`define SMT_OFF_DBG 6'h0E
`define SMT_OFF_LOW_HALF_COUNT 6'h20
`define SMT_OFF_HIGH_HALF_COUNT 6'h21
`define SMT_OFF_LTOP 6'h26
`define SMT_OFF_HTOP 6'h27
`define SMT_OFF_LM0 6'h28
`define SMT_OFF_LM1 6'h2A
`define SMT_OFF_LM2 6'h2C
`define SMT_OFF_HM0 6'h29
`define SMT_OFF_HM1 6'h2B
`define SMT_OFF_HM2 6'h2D

`define SMT_BIT_ENABLE 0
`define SMT_POS_PRESC 1
`define SMT_BIT_SPLIT 0
`define SMT_POS_CMD 2
`define SMT_BIT_LOW_UNDERFLOW_FLAG 0
`define SMT_BIT_HIGH_UNDERFLOW_FLAG 1
`define SMT_POS_LMATCH 4

`define SMT_RST_CTRL 8'h00
`define SMT_RST_TOP 8'hFF
`define SMT_RST_MATCH 8'h00
`define SMT_IRQ_MASK 8'h73
`define SMT_PIN_MASK 8'h77
`define SMT_CTRL_MASK 8'h0F

`define SMT_CMD_RESTART 2'h2
`define SMT_CMD_RESET 2'h3
`define SMT_COMMAND_TARGET_BOTH 2'h3

`define SMT_PRESC_MAX 10'h3FF

`endif

// ===== common/smt_pkg.sv
/*
 types of the dual 8-bit timer control block.
 needs nothing from smt_cfg.svh; the bus state codes are set here.
*/
package smt_pkg;
   typedef enum logic [1:0] {
      SMT_BUS_IDLE = 2'b00,
      SMT_BUS_ACK = 2'b01,
      SMT_BUS_WAIT = 2'b10
   } smt_bus_e;

   typedef logic [7:0] smt_byte_t;
endpackage

// ===== common/smt_tick_if.sv
/*
 interface carrying the prescaler selection and the count tick between the
 control top and the prescaler. single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface smt_tick_if;
   logic run;
   logic restart;
   logic [2:0] sel;
   logic tick;
   modport ctrl (output run, output restart, output sel, input tick);
   modport presc (input run, input restart, input sel, output tick);
endinterface
`default_nettype wire

// ===== verif/smt_pin_model.sv
/*
 port pins beyond the wave outputs.
 assumes active-low pad enables and no pull on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module smt_pin_model
   import smt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [5:0] pad_i,
   input wire logic [5:0] pad_en_i,
   output logic [5:0] pin_o
);
   logic [5:0] last_q;
   // released pins float: show the inverse of the last driven level
   assign pin_o = (pad_i & ~pad_en_i) | (~last_q & pad_en_i);
   always_ff @(posedge clk_i) begin
      last_q <= rst_i ? 6'h00 : ((pad_i & ~pad_en_i) | (last_q & pad_en_i));
   end
endmodule
`default_nettype wire

// ===== verif/smt_split_timer_asserts.sv
/*
 concurrent checks on the ports of the dual 8-bit timer control block.
 assumes the cfg header and one clock with synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smt_cfg.svh"
module smt_split_timer_asserts
   import smt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq_o,
   input wire logic [5:0] wave_pad_o,
   input wire logic [5:0] wave_pad_en_o,
   input wire logic [5:0] custom_logic_block_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic rd;
   logic [5:0] ix;
   assign rd = wb_ack_o && !wb_we_i;
   assign ix = wb_adr_i[7:2];
   sequence s_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_taken |=> s_answer)
      else $error("ack missing or too long");
   a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
      else $error("upper read data set");
   a_cmd_zero: assert property (rd && ix inside {`SMT_OFF_CMDCLR, `SMT_OFF_CMDSET}
      |-> wb_dat_o == 32'h0) else $error("command field read nonzero");
   a_hole_zero: assert property (rd && ix == 6'h06 |-> wb_dat_o == 32'h0)
      else $error("reserved offset read nonzero");
   a_pin_enable: assert property (rd && ix == `SMT_OFF_PINEN
      |-> wave_pad_en_o == ~{wb_dat_o[6:4], wb_dat_o[2:0]}) else $error("pad enable wrong");
   a_pad_logic: assert property (((wave_pad_o ^ custom_logic_block_o) & ~wave_pad_en_o) == 0)
      else $error("driven pad differs from compare output");
   a_irq_masked: assert property (rd && ix == `SMT_OFF_IRQEN && wb_dat_o == 0 |-> !irq_o)
      else $error("irq with all sources masked");
endmodule
bind smt_split_timer smt_split_timer_asserts i_smt_split_timer_asserts (.clk_i(clk_i),
   .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wave_pad_o(wave_pad_o),
   .wave_pad_en_o(wave_pad_en_o), .custom_logic_block_o(custom_logic_block_o));
`default_nettype wire

// ===== verif/smt_split_timer_test.sv
/*
 self-checking bench of the dual 8-bit timer control block.
 assumes the cfg header, smt_pkg and the pin model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smt_cfg.svh"
module smt_split_timer_test
   import smt_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'h1;
   logic [31:0] rdat;
   logic ack, irq;
   logic [5:0] pad, pad_en, clb, pin;
   int err_total = 0;
   int n_compared = 0;
   int cyc_cnt = 0;
   int dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
   smt_byte_t v;
   always #25 clk_i = ~clk_i;
   smt_split_timer i_smt_split_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .wave_pad_o(pad),
      .wave_pad_en_o(pad_en), .custom_logic_block_o(clb));
   smt_pin_model i_smt_pin_model (.clk_i(clk_i), .rst_i(rst_i), .pad_i(pad),
      .pad_en_i(pad_en), .pin_o(pin));
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [5:0] a, input smt_byte_t d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 2'b00, 24'h0, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      v = rdat[7:0];
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rc(input string nm, input logic [5:0] a, input smt_byte_t e);
      xfer(1'b0, a, 8'h00);
      chk(nm, v, e);
   endtask
   task automatic settle;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 95000) begin
         err_total++;
         end_of_test;
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("pad_en", {2'b00, pad_en}, 8'h3F);
      rc("ctrl", `SMT_OFF_CTRL, 8'h00);
      rc("ltop", `SMT_OFF_LTOP, 8'hFF);
      rc("hm2", `SMT_OFF_HM2, 8'h00);
      sel <= 4'h0;
      xfer(1'b1, `SMT_OFF_HTOP, 8'h12);
      sel <= 4'h1;
      rc("sel0", `SMT_OFF_HTOP, 8'hFF);
      xfer(1'b1, `SMT_OFF_CTRL, 8'hFE);
      rc("ctrl", `SMT_OFF_CTRL, 8'h0E);
      xfer(1'b1, `SMT_OFF_CTRL, 8'h00);
      xfer(1'b1, 6'h06, 8'hFF);
      rc("hole", 6'h06, 8'h00);
      xfer(1'b1, `SMT_OFF_IRQEN, 8'hFF);
      rc("irqen", `SMT_OFF_IRQEN, 8'h73);
      xfer(1'b1, `SMT_OFF_CMDSET, 8'h01);
      rc("cmd", `SMT_OFF_CMDSET, 8'h00);
      xfer(1'b1, `SMT_OFF_FORCE, 8'h25);
      settle;
      chk("clb", {2'b00, clb}, 8'h15);
      chk("pad", {2'b00, pad}, 8'h00);
      chk("pad_en", {2'b00, pad_en}, 8'h3F);
      xfer(1'b1, `SMT_OFF_PINEN, 8'h77);
      settle;
      chk("pad_en", {2'b00, pad_en}, 8'h00);
      chk("pin", {2'b00, pin}, 8'h15);
      xfer(1'b1, `SMT_OFF_SPLIT, 8'h01);
      xfer(1'b1, `SMT_OFF_LTOP, 8'h03);
      xfer(1'b1, `SMT_OFF_HTOP, 8'h05);
      xfer(1'b1, `SMT_OFF_LM0, 8'h01);
      xfer(1'b1, `SMT_OFF_LM1, 8'h02);
      xfer(1'b1, `SMT_OFF_LM2, 8'h09);
      xfer(1'b1, `SMT_OFF_CTRL, 8'h01);
      repeat (20) @(posedge clk_i);
      xfer(1'b1, `SMT_OFF_CTRL, 8'h00);
      rc("flags", `SMT_OFF_IRQFL, 8'h33);
      rc("flags", `SMT_OFF_IRQFL, 8'h33);
      chk("irq", {7'h0, irq}, 8'h01);
      xfer(1'b1, `SMT_OFF_IRQEN, 8'h00);
      settle;
      chk("irq", {7'h0, irq}, 8'h00);
      rc("irqen", `SMT_OFF_IRQEN, 8'h00);
      xfer(1'b1, `SMT_OFF_IRQEN, 8'h73);
      xfer(1'b1, `SMT_OFF_IRQFL, 8'h01);
      rc("flags", `SMT_OFF_IRQFL, 8'h32);
      xfer(1'b1, `SMT_OFF_IRQFL, 8'h32);
      rc("flags", `SMT_OFF_IRQFL, 8'h00);
      settle;
      chk("irq", {7'h0, irq}, 8'h00);
      xfer(1'b1, `SMT_OFF_LTOP, 8'hFF);
      xfer(1'b1, `SMT_OFF_CTRL, 8'h01);
      xfer(1'b1, `SMT_OFF_LOW_HALF_COUNT, 8'h40);
      xfer(1'b0, `SMT_OFF_LOW_HALF_COUNT, 8'h00);
      chk("low_half_count", {7'h0, (v inside {[8'h3A:8'h40]})}, 8'h01);
      xfer(1'b1, `SMT_OFF_CTRL, 8'h0F);
      xfer(1'b1, `SMT_OFF_CMDSET, 8'h0B);
      rc("low_half_count", `SMT_OFF_LOW_HALF_COUNT, 8'h00);
      rc("high_half_count", `SMT_OFF_HIGH_HALF_COUNT, 8'h00);
      xfer(1'b1, `SMT_OFF_CMDSET, 8'h0F);
      rc("pinen", `SMT_OFF_PINEN, 8'h77);
      for (int c = 0; c < 8; c++) begin
         xfer(1'b1, `SMT_OFF_CTRL, 8'h00);
         xfer(1'b1, `SMT_OFF_LOW_HALF_COUNT, 8'hFF);
         xfer(1'b1, `SMT_OFF_CTRL, {4'h0, c[2:0], 1'b1});
         repeat (60 * dv[c] - 2) @(posedge clk_i);
         xfer(1'b1, `SMT_OFF_CTRL, 8'h00);
         xfer(1'b0, `SMT_OFF_LOW_HALF_COUNT, 8'h00);
         chk("presc", {7'h0, ((8'hFF - v) inside {[8'd59:8'd61]})}, 8'h01);
      end
      xfer(1'b1, `SMT_OFF_CMDSET, 8'h0F);
      rc("pinen", `SMT_OFF_PINEN, 8'h00);
      rc("ltop", `SMT_OFF_LTOP, 8'hFF);
      end_of_test;
   end
endmodule
`default_nettype wire

// ===== verilog/smt_prescaler.sv
/*
 prescaler: one-cycle tick at clk divided by 1..1024.
 assumes synchronous active-high reset and the smt_tick_if carrier.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smt_cfg.svh"
module smt_prescaler
   import smt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   smt_tick_if.presc tk
);
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } smt_presc_s;

   smt_presc_s q, d;
   logic [9:0] lim;

   always_comb begin
      case (tk.sel)
         3'h0: lim = 10'h000;
         3'h1: lim = 10'h001;
         3'h2: lim = 10'h003;
         3'h3: lim = 10'h007;
         3'h4: lim = 10'h00F;
         3'h5: lim = 10'h03F;
         3'h6: lim = 10'h0FF;
         default: lim = `SMT_PRESC_MAX;
      endcase
   end

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (!tk.run || tk.restart) begin
         d.cnt = 10'h000;
      end else if (q.cnt >= lim) begin
         d.cnt = 10'h000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 10'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;
endmodule
`default_nettype wire

// ===== verilog/smt_split_timer.sv
/*
 control and register layer of a 16-bit timer run as two 8-bit down
 counters, with classic wishbone register access and one level interrupt.
 assumes a single clock, synchronous active-high reset, byte-wide registers
 at word addresses (byte address = offset * 4), data in bits 7:0.
*/
// How it works
// - prescale code 0..7 divides clock by 1,2,4,8,16,64,256,1024
// - enable bit 0 of control runs the timer; cleared holds it stopped
// - dual select bit splits the timer into low and high 8-bit units
// - split map places low/high count, top and match at byte pairs
// - high channel pin enable lets waveform drive output n+3
// - low channel pin enable lets waveform drive output n
// - stopped timer: high forced value sets output n+3 directly
// - stopped timer: low forced value sets output n directly
// - pad output shows forced value only when its pin enable is set
// - logic-block output ignores pin enables and carries compare output
// - underflow flags set at bottom, stay, clear on written one
// - low match flags set on count equal match, clear on written one
// - command reads zero; restart acts even when enabled, reset ignored when enabled; both halves
// - software count write beats simultaneous count or reload
`timescale 1ns/1ps
`default_nettype none
`include "smt_cfg.svh"
module smt_split_timer
   import smt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   output logic [5:0] wave_pad_o,
   output logic [5:0] wave_pad_en_o,
   output logic [5:0] custom_logic_block_o
);
   typedef struct packed {
      smt_bus_e bus;
      logic [31:0] rdat;
      smt_byte_t ctrl;
      smt_byte_t pin_en;
      smt_byte_t forced;
      logic split;
      smt_byte_t irq_en;
      smt_byte_t flags;
      logic run_while_halted;
      smt_byte_t low_half_count;
      smt_byte_t high_half_count;
      smt_byte_t ltop;
      smt_byte_t htop;
      smt_byte_t [2:0] lmatch;
      smt_byte_t [2:0] hmatch;
      logic [5:0] wave;
      logic [5:0] pad;
      logic [5:0] pad_en;
      logic [5:0] clb;
      logic irq;
   } smt_state_s;

   smt_state_s q, d;
   smt_tick_if tk ();

   // strip byte index from a word address
   function automatic logic [5:0] reg_index(input logic [7:0] adr);
      reg_index = adr[7:2];
   endfunction

   // value of one 8-bit counter after a tick: down count, reload at bottom
   function automatic smt_byte_t count_step(input smt_byte_t cnt, input smt_byte_t top);
      count_step = (cnt == 8'h00) ? top : cnt - 8'h01;
   endfunction

   logic wr, rd_ok, enabled, tick;
   logic [5:0] idx;
   logic [7:0] wd;
   logic [1:0] cmd, cmd_tgt;
   logic do_restart, do_reset;
   logic [7:0] fl_set, fl_clr;
   logic [5:0] cmp_out;

   smt_prescaler u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tk(tk)
   );

   assign enabled = q.ctrl[`SMT_BIT_ENABLE];
   assign tk.run = enabled;
   assign tk.sel = q.ctrl[`SMT_POS_PRESC +: 3];
   assign tk.restart = do_restart;
   assign tick = tk.tick;

   assign idx = reg_index(wb_adr_i);
   assign wd = wb_dat_i[7:0];
   // a write commits at the edge where ack is seen, while the request still stands
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && q.bus == SMT_BUS_ACK;
   assign rd_ok = wb_cyc_i && wb_stb_i && !wb_we_i && q.bus == SMT_BUS_IDLE;
   assign cmd = wd[`SMT_POS_CMD +: 2];
   assign cmd_tgt = wd[1:0];

   always_comb begin
      do_restart = 1'b0;
      do_reset = 1'b0;
      if (wr && idx == `SMT_OFF_CMDSET && cmd_tgt == `SMT_COMMAND_TARGET_BOTH) begin
         do_restart = cmd == `SMT_CMD_RESTART;
         do_reset = cmd == `SMT_CMD_RESET && !enabled;
      end
   end

   always_comb begin
      fl_set = 8'h00;
      fl_clr = 8'h00;
      if (enabled && tick && q.split) begin
         fl_set[`SMT_BIT_LOW_UNDERFLOW_FLAG] = q.low_half_count == 8'h00;
         fl_set[`SMT_BIT_HIGH_UNDERFLOW_FLAG] = q.high_half_count == 8'h00;
      end
      for (int i = 0; i < 3; i++) begin
         fl_set[`SMT_POS_LMATCH + i] = enabled && q.split && q.low_half_count == q.lmatch[i];
      end
      if (wr && idx == `SMT_OFF_IRQFL) begin
         fl_clr = wd & `SMT_IRQ_MASK;
      end
   end

   // compare output of the waveform generator, frequency style toggle on match
   always_comb begin
      cmp_out = q.wave;
      if (!enabled) begin
         cmp_out = {q.forced[6:4], q.forced[2:0]};
      end
   end

   always_comb begin
      d = q;
      d.bus = SMT_BUS_IDLE;
      // bus: one-cycle ack after request, ack drops the cycle after
      if (q.bus == SMT_BUS_IDLE && wb_cyc_i && wb_stb_i) begin
         d.bus = SMT_BUS_ACK;
      end
      d.rdat = 32'h00000000;
      if (rd_ok) begin
         case (idx)
            `SMT_OFF_CTRL: d.rdat[7:0] = q.ctrl;
            `SMT_OFF_PINEN: d.rdat[7:0] = q.pin_en;
            `SMT_OFF_FORCE: d.rdat[7:0] = q.forced;
            `SMT_OFF_SPLIT: d.rdat[7:0] = {7'h00, q.split};
            `SMT_OFF_CMDCLR: d.rdat[7:0] = 8'h00;
            `SMT_OFF_CMDSET: d.rdat[7:0] = 8'h00;
            `SMT_OFF_IRQEN: d.rdat[7:0] = q.irq_en;
            `SMT_OFF_IRQFL: d.rdat[7:0] = q.flags;
            `SMT_OFF_DBG: d.rdat[7:0] = {7'h00, q.run_while_halted};
            `SMT_OFF_LOW_HALF_COUNT: d.rdat[7:0] = q.low_half_count;
            `SMT_OFF_HIGH_HALF_COUNT: d.rdat[7:0] = q.high_half_count;
            `SMT_OFF_LTOP: d.rdat[7:0] = q.ltop;
            `SMT_OFF_HTOP: d.rdat[7:0] = q.htop;
            `SMT_OFF_LM0: d.rdat[7:0] = q.lmatch[0];
            `SMT_OFF_LM1: d.rdat[7:0] = q.lmatch[1];
            `SMT_OFF_LM2: d.rdat[7:0] = q.lmatch[2];
            `SMT_OFF_HM0: d.rdat[7:0] = q.hmatch[0];
            `SMT_OFF_HM1: d.rdat[7:0] = q.hmatch[1];
            `SMT_OFF_HM2: d.rdat[7:0] = q.hmatch[2];
            default: d.rdat = 32'h00000000;
         endcase
      end

      // counting on the shared tick; both units down count to bottom
      if (enabled && tick && q.split) begin
         d.low_half_count = count_step(q.low_half_count, q.ltop);
         d.high_half_count = count_step(q.high_half_count, q.htop);
         for (int i = 0; i < 3; i++) begin
            if (q.low_half_count == q.lmatch[i]) begin
               d.wave[i] = !q.wave[i];
            end
            if (q.high_half_count == q.hmatch[i]) begin
               d.wave[i + 3] = !q.wave[i + 3];
            end
         end
      end
      if (do_restart) begin
         d.low_half_count = 8'h00;
         d.high_half_count = 8'h00;
         d.wave = 6'h00;
      end
      if (do_reset) begin
         d.low_half_count = 8'h00;
         d.high_half_count = 8'h00;
         d.ltop = `SMT_RST_TOP;
         d.htop = `SMT_RST_TOP;
         d.lmatch = '0;
         d.hmatch = '0;
         d.wave = 6'h00;
         d.forced = `SMT_RST_CTRL;
         d.pin_en = `SMT_RST_CTRL;
      end
      if (!enabled) begin
         d.wave = {q.forced[6:4], q.forced[2:0]};
      end

      d.flags = (q.flags & ~fl_clr) | fl_set;

      if (wr) begin
         case (idx)
            `SMT_OFF_CTRL: d.ctrl = wd & `SMT_CTRL_MASK;
            `SMT_OFF_PINEN: d.pin_en = wd & `SMT_PIN_MASK;
            `SMT_OFF_FORCE: d.forced = wd & `SMT_PIN_MASK;
            `SMT_OFF_SPLIT: d.split = wd[`SMT_BIT_SPLIT];
            `SMT_OFF_IRQEN: d.irq_en = wd & `SMT_IRQ_MASK;
            `SMT_OFF_DBG: d.run_while_halted = wd[0];
            `SMT_OFF_LOW_HALF_COUNT: d.low_half_count = wd;
            `SMT_OFF_HIGH_HALF_COUNT: d.high_half_count = wd;
            `SMT_OFF_LTOP: d.ltop = wd;
            `SMT_OFF_HTOP: d.htop = wd;
            `SMT_OFF_LM0: d.lmatch[0] = wd;
            `SMT_OFF_LM1: d.lmatch[1] = wd;
            `SMT_OFF_LM2: d.lmatch[2] = wd;
            `SMT_OFF_HM0: d.hmatch[0] = wd;
            `SMT_OFF_HM1: d.hmatch[1] = wd;
            `SMT_OFF_HM2: d.hmatch[2] = wd;
            default: d.split = d.split;
         endcase
      end

      // pad: pin enable gates the waveform onto the pad
      d.pad_en = ~{q.pin_en[6:4], q.pin_en[2:0]};
      d.pad = cmp_out & {q.pin_en[6:4], q.pin_en[2:0]};
      d.clb = cmp_out;
      d.irq = |(d.flags & q.irq_en);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.ltop <= `SMT_RST_TOP;
         q.htop <= `SMT_RST_TOP;
         q.pad_en <= 6'h3F;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.bus == SMT_BUS_ACK;
   assign wb_dat_o = q.rdat;
   assign irq_o = q.irq;
   assign wave_pad_o = q.pad;
   assign wave_pad_en_o = q.pad_en;
   assign custom_logic_block_o = q.clb;
endmodule
`default_nettype wire
